// *** verilog/acsc_params.svh ***
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH
// register indices, byte address is four times the index
`define ACSC_IDX_SEQ_LEN 8'h04
`define ACSC_IDX_CTRL 8'h05
`define ACSC_IDX_STATUS 8'h06
`define ACSC_IDX_RESULT 8'h08
// control register fields
`define ACSC_BIT_JUSTIFY 7
`define ACSC_BIT_SIGNED 6
`define ACSC_BIT_SCAN 5
`define ACSC_BIT_MULTI 4
`define ACSC_CHAN_MSB 2
// length register fields
`define ACSC_BIT_LOWRES 7
`define ACSC_LEN_MSB 3
// status register fields
`define ACSC_BIT_COMPLETE 7
`define ACSC_BIT_OVERRUN 4
`define ACSC_BIT_BUSY 3
// reset values
`define ACSC_RST_CTRL 8'h00
`define ACSC_RST_SEQ_LEN 8'h04
`endif

// *** verilog/acsc_pkg.sv ***
package acsc_pkg;
  typedef enum logic [1:0] {ACSC_IDLE, ACSC_REQ, ACSC_WAIT} acsc_state_t;
  typedef logic [2:0] acsc_chan_t;
  typedef logic [15:0] acsc_word_t;
endpackage : acsc_pkg

// *** verilog/acsc_ctrl.sv ***
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "acsc_params.svh"
// Summary of operation
// - a write to the sequence control register aborts any running sequence and starts a new one.
// - the sequence control register sits at index 0x0005 and is readable and writable at any time.
// - justify bit 7 gives left placement at 0 and right placement at 1.
// - sign bit 6 gives unsigned results at 0 and two's complement at 1.
// - signed form applies only to left placement; right placement is always unsigned.
// - scan bit 5 runs one sequence at 0 and back to back sequences at 1.
// - with multi bit 4 at 0 every conversion uses the one coded channel.
// - with multi bit 4 at 1 the sequence visits as many channels as the length setting.
// - in multi mode the code gives the first channel and each next one adds one.
// - an incremented channel past the highest wraps to the lowest.
// - channel codes 000 to 111 map to inputs zero to seven in order.
// - results sit at bits 8-15, 0-7, 6-15 or 0-9 by resolution and placement.
// - starting a sequence by write or by external trigger clears the overrun flag.
module acsc_ctrl
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core
  output logic conv_start,
  output acsc_pkg::acsc_chan_t conv_channel,
  input wire logic conv_done,
  input wire logic [9:0] conv_raw,
  // external trigger pin
  input wire logic ext_trigger
);
  import acsc_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic acsc_word_t fmt_result(input logic [9:0] raw,
    input logic lowres, input logic right, input logic sgn);
    acsc_word_t w;
    w = 16'h0000;
    if (lowres)
      w = right ? {8'h00, raw[9:2]} : {raw[9:2], 8'h00};
    else
      w = right ? {6'h00, raw} : {raw, 6'h00};
    if (sgn && !right)
      w[15] = ~w[15];
    return w;
  endfunction : fmt_result

  function automatic logic [31:0] reg_byte_addr(input logic [7:0] idx);
    return {22'h00_0000, idx, 2'b00};
  endfunction : reg_byte_addr

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire logic acc = psel && penable;
  wire logic hit_ctrl = paddr == reg_byte_addr(`ACSC_IDX_CTRL);
  wire logic hit_len = paddr == reg_byte_addr(`ACSC_IDX_SEQ_LEN);
  wire logic hit_stat = paddr == reg_byte_addr(`ACSC_IDX_STATUS);
  wire logic hit_res = paddr == reg_byte_addr(`ACSC_IDX_RESULT);
  wire logic hit_any = hit_ctrl || hit_len || hit_stat || hit_res;
  wire logic wr_ctrl = acc && pwrite && hit_ctrl;
  wire logic wr_len = acc && pwrite && hit_len;
  wire logic wr_stat = acc && pwrite && hit_stat;
  wire logic rd_res = acc && !pwrite && hit_res;

  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  // ------------------------------------------------------------
  // external trigger synchroniser
  // ------------------------------------------------------------
  logic trg_s1_ff;
  logic trg_s2_ff;
  logic trg_s3_ff;
  logic trg_lvl_ff;
  wire logic trg_agree = trg_s2_ff == trg_s3_ff;
  wire logic trg_rise = trg_agree && trg_s3_ff && !trg_lvl_ff;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trg_s1_ff <= 1'b0;
      trg_s2_ff <= 1'b0;
      trg_s3_ff <= 1'b0;
      trg_lvl_ff <= 1'b0;
    end
    else
    begin
      trg_s1_ff <= ext_trigger;
      trg_s2_ff <= trg_s1_ff;
      trg_s3_ff <= trg_s2_ff;
      if (trg_agree)
        trg_lvl_ff <= trg_s3_ff;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [7:0] len_ff;
  wire logic seq_start = wr_ctrl || trg_rise;
  wire logic [7:0] nxt_ctrl = wr_ctrl ? pwdata[7:0] : ctrl_ff;
  wire logic [7:0] nxt_len = wr_len ? pwdata[7:0] : len_ff;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_ff <= `ACSC_RST_CTRL;
      len_ff <= `ACSC_RST_SEQ_LEN;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      len_ff <= nxt_len;
    end
  end

  wire logic result_justify_sel = ctrl_ff[`ACSC_BIT_JUSTIFY];
  wire logic result_signed_sel = ctrl_ff[`ACSC_BIT_SIGNED];
  wire logic scan_sel = ctrl_ff[`ACSC_BIT_SCAN];
  wire logic multi_channel_sel = ctrl_ff[`ACSC_BIT_MULTI];
  wire acsc_chan_t channel_code = ctrl_ff[`ACSC_CHAN_MSB:0];
  wire logic low_resolution_sel = len_ff[`ACSC_BIT_LOWRES];
  wire logic [3:0] seq_length = len_ff[`ACSC_LEN_MSB:0];
  // zero length counts as eight conversions
  wire logic [3:0] seq_last = (seq_length == 4'h0) ? 4'h7 :
    seq_length - 4'h1;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  acsc_state_t state_ff;
  acsc_state_t nxt_state;
  acsc_chan_t chan_ff;
  acsc_chan_t nxt_chan;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic complete_ff;
  logic overrun_ff;
  logic res_valid_ff;
  acsc_word_t result_ff;
  logic start_ff;

  wire logic conv_fin = (state_ff == ACSC_WAIT) && conv_done && !seq_start;
  wire logic seq_end = conv_fin && (cnt_ff == seq_last);
  wire acsc_chan_t chan_inc = chan_ff + 3'h1;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ACSC_IDLE:
        nxt_state = ACSC_IDLE;
      ACSC_REQ:
        nxt_state = ACSC_WAIT;
      ACSC_WAIT:
        if (conv_fin)
        begin
          nxt_state = (seq_end && !scan_sel) ? ACSC_IDLE : ACSC_REQ;
          nxt_cnt = seq_end ? 4'h0 : cnt_ff + 4'h1;
          if (seq_end)
            nxt_chan = channel_code;
          else if (multi_channel_sel)
            nxt_chan = chan_inc;
          else
            nxt_chan = channel_code;
        end
      default:
        nxt_state = ACSC_IDLE;
    endcase
    if (seq_start)
    begin
      nxt_state = ACSC_REQ;
      nxt_cnt = 4'h0;
      nxt_chan = nxt_ctrl[`ACSC_CHAN_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ACSC_IDLE;
      chan_ff <= 3'h0;
      cnt_ff <= 4'h0;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      cnt_ff <= nxt_cnt;
      start_ff <= nxt_state == ACSC_REQ;
    end
  end

  assign conv_start = start_ff;
  assign conv_channel = chan_ff;

  // ------------------------------------------------------------
  // result and flags
  // ------------------------------------------------------------
  wire acsc_word_t nxt_result = fmt_result(conv_raw, low_resolution_sel,
    result_justify_sel, result_signed_sel);
  wire logic ovr_set = conv_fin && res_valid_ff && !rd_res;
  wire logic ovr_clr = seq_start ||
    (wr_stat && pwdata[`ACSC_BIT_OVERRUN]);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_ff <= 16'h0000;
      res_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
      complete_ff <= 1'b0;
    end
    else
    begin
      if (conv_fin)
        result_ff <= nxt_result;
      res_valid_ff <= conv_fin || (res_valid_ff && !rd_res);
      overrun_ff <= ovr_set || (overrun_ff && !ovr_clr);
      complete_ff <= seq_end || (complete_ff && !seq_start &&
        !(wr_stat && pwdata[`ACSC_BIT_COMPLETE]));
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire logic busy = state_ff != ACSC_IDLE;
  wire logic [7:0] status_word = {complete_ff, 2'b00, overrun_ff, busy,
    chan_ff};
  wire logic [31:0] rd_data = hit_ctrl ? {24'h00_0000, ctrl_ff} :
    hit_len ? {24'h00_0000, len_ff} :
    hit_stat ? {24'h00_0000, status_word} :
    hit_res ? {16'h0000, result_ff} : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_data;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_abort_restart;
    @(posedge ref_clk) disable iff (!arst_n)
    wr_ctrl |=> (state_ff == ACSC_REQ) && conv_start;
  endproperty
  a_abort_restart: assert property (p_abort_restart)
    else $error("write did not restart sequence");

  property p_ctrl_store;
    @(posedge ref_clk) disable iff (!arst_n)
    wr_ctrl |=> ctrl_ff == $past(pwdata[7:0]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store)
    else $error("control write not stored");

  property p_right_unsigned;
    @(posedge ref_clk) disable iff (!arst_n)
    (conv_fin && result_justify_sel && !low_resolution_sel) |=>
      result_ff == {6'h00, $past(conv_raw)};
  endproperty
  a_right_unsigned: assert property (p_right_unsigned)
    else $error("right placement wrong");

  property p_left_signed;
    @(posedge ref_clk) disable iff (!arst_n)
    (conv_fin && !result_justify_sel && result_signed_sel &&
      low_resolution_sel) |=>
      result_ff == {~$past(conv_raw[9]), $past(conv_raw[8:2]), 8'h00};
  endproperty
  a_left_signed: assert property (p_left_signed)
    else $error("signed left result wrong");

  property p_single_stop;
    @(posedge ref_clk) disable iff (!arst_n)
    (seq_end && !scan_sel && !seq_start) |=> state_ff == ACSC_IDLE;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single sequence did not stop");

  property p_scan_repeat;
    @(posedge ref_clk) disable iff (!arst_n)
    (seq_end && scan_sel) |=> conv_start && conv_channel == channel_code;
  endproperty
  a_scan_repeat: assert property (p_scan_repeat)
    else $error("scan did not repeat");

  property p_single_chan;
    @(posedge ref_clk) disable iff (!arst_n)
    (conv_start && !multi_channel_sel) |-> conv_channel == channel_code;
  endproperty
  a_single_chan: assert property (p_single_chan)
    else $error("single channel mode used wrong input");

  property p_multi_inc;
    @(posedge ref_clk) disable iff (!arst_n)
    (conv_fin && !seq_end && multi_channel_sel) |=>
      conv_channel == $past(conv_channel) + 3'h1;
  endproperty
  a_multi_inc: assert property (p_multi_inc)
    else $error("channel did not advance");

  property p_ovr_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    seq_start |=> !overrun_ff;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun not cleared on start");

endmodule : acsc_ctrl

// *** dv/acsc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module acsc_ctrl_tb_top;
  import acsc_pkg::*;
  localparam logic [31:0] A_LEN = 32'h0000_0010;
  localparam logic [31:0] A_CTRL = 32'h0000_0014;
  localparam logic [31:0] A_STAT = 32'h0000_0018;
  localparam logic [31:0] A_RES = 32'h0000_0020;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic conv_start, conv_done, ext_trigger, lo;
  logic [9:0] conv_raw;
  logic [7:0] c;
  acsc_chan_t conv_channel;
  acsc_chan_t chq[$];
  int fails, compares, len;

  acsc_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_raw(conv_raw), .ext_trigger(ext_trigger));

  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end

  // record every conversion request with its channel
  always @(posedge ref_clk)
    if (conv_start === 1'b1) chq.push_back(conv_channel);

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  function automatic logic [31:0] fmt(logic [9:0] r, logic l, logic rj,
                                      logic sg);
    logic [15:0] v;
    v = l ? {r[9:2], 8'h00} : {r, 6'h00};
    if (rj) v = l ? {8'h00, r[9:2]} : {6'h00, r};
    else if (sg) v[15] = ~v[15];
    return {16'h0000, v};
  endfunction : fmt

  // one conversion: wait for the request, answer, optionally read result
  task automatic conv(acsc_chan_t ch, logic l, logic [7:0] cf, logic rdres);
    int n;
    logic [9:0] r;
    r = 10'($urandom);
    n = 0;
    while (chq.size() == 0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    check("conv_channel", 32'(chq.pop_front()), 32'(ch));
    repeat (1 + $urandom % 3) @(posedge ref_clk);
    conv_done <= 1;
    conv_raw <= r;
    @(posedge ref_clk);
    conv_done <= 0;
    conv_raw <= ~r;
    if (rdres)
    begin
      apb(0, A_RES, 0);
      check("result", rd, fmt(r, l, cf[7], cf[6]));
    end
  endtask : conv

  task automatic run_seq(logic [7:0] cf, int n, logic l, logic rdres);
    acsc_chan_t ch;
    ch = cf[2:0];
    for (int k = 0; k < n; k++)
    begin
      conv(ch, l, cf, rdres);
      if (cf[4]) ch = ch + 3'd1;
    end
  endtask : run_seq

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    {psel, penable, pwrite, conv_done, ext_trigger, arst_n} = '0;
    paddr = '0;
    pwdata = '0;
    conv_raw = '0;
    fails = 0;
    compares = 0;
    void'($urandom(57437));
    repeat (5) @(posedge ref_clk);
    arst_n <= 1;
    apb(0, A_CTRL, 0);
    check("ctrl_reset", rd, 32'h0000_0000);
    apb(0, A_LEN, 0);
    check("len_reset", rd, 32'h0000_0004);
    apb(0, 32'h0000_003c, 0);
    check("unmapped_err", 32'(err), 32'h0000_0001);
    check("unmapped_rd", rd, 32'h0000_0000);
    for (int i = 0; i < 40; i++)
    begin
      c = (i == 0) ? 8'h57 : 8'($urandom) & 8'hdf;
      len = (i == 0) ? 8 : 1 + $urandom % 8;
      lo = 1'($urandom);
      apb(1, A_LEN, {24'h0000_00, lo, 3'b000, 4'(len)});
      apb(1, A_CTRL, {24'h0000_00, c});
      apb(0, A_CTRL, 0);
      check("ctrl_readback", rd & 32'h0000_00f7, 32'(c & 8'hf7));
      run_seq(c, len, lo, 1);
      apb(0, A_STAT, 0);
      check("seq_complete", 32'(rd[7]), 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      check("single_idle", chq.size(), 0);
    end
    // abort in mid conversion
    apb(1, A_LEN, 32'h0000_0003);
    apb(1, A_CTRL, 32'h0000_0012);
    repeat (3) @(posedge ref_clk);
    check("abort_first", 32'(chq.pop_front()), 32'h0000_0002);
    apb(1, A_CTRL, 32'h0000_0015);
    run_seq(8'h15, 3, 0, 1);
    // overrun cleared by trigger, then by write
    apb(1, A_CTRL, 32'h0000_0001);
    run_seq(8'h01, 2, 0, 0);
    apb(0, A_STAT, 0);
    check("overrun_set", 32'(rd[4]), 32'h0000_0001);
    chq.delete();
    ext_trigger <= 1;
    repeat (8) @(posedge ref_clk);
    ext_trigger <= 0;
    apb(0, A_STAT, 0);
    check("overrun_trig", 32'(rd[4]), 32'h0000_0000);
    run_seq(8'h01, 3, 0, 1);
    run_seq(8'h01, 0, 0, 0);
    apb(1, A_CTRL, 32'h0000_0001);
    run_seq(8'h01, 2, 0, 0);
    repeat (3) @(posedge ref_clk);
    chq.delete();
    apb(1, A_CTRL, 32'h0000_0001);
    apb(0, A_STAT, 0);
    check("overrun_write", 32'(rd[4]), 32'h0000_0000);
    run_seq(8'h01, 3, 0, 1);
    // continuous mode repeats and reloads the start channel
    apb(1, A_LEN, 32'h0000_0002);
    apb(1, A_CTRL, 32'h0000_0037);
    run_seq(8'h37, 2, 0, 1);
    run_seq(8'h37, 2, 0, 1);
    chq.delete();
    apb(1, A_CTRL, 32'h0000_0000);
    run_seq(8'h00, 2, 0, 1);
    repeat (20) @(posedge ref_clk);
    check("scan_stopped", chq.size(), 0);
    final_report();
  end
endmodule : acsc_ctrl_tb_top
